/* File: core/msg_parser_pkg.sv */
package msg_parser_pkg;

  // ---------------------------------------------------------------------------
  // Character codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CHR_NEWLINE = 8'h0a;
  localparam logic [7:0] CHR_COLON   = 8'h3a;
  localparam logic [7:0] CHR_SEMI    = 8'h3b;
  localparam logic [7:0] CHR_QUERY   = 8'h3f;
  localparam logic [7:0] CHR_SPACE   = 8'h20;
  localparam logic [7:0] CHR_STAR    = 8'h2a;
  localparam logic [7:0] CASE_BIT    = 8'h20;

  // ---------------------------------------------------------------------------
  // Keyword table layout
  // ---------------------------------------------------------------------------
  localparam int KW_CHARS    = 12;
  localparam int KW_COUNT    = 16;
  localparam int KW_IDX_W    = 4;
  localparam int DEPTH_W     = 3;
  localparam int PARAM_CHARS = 16;
  localparam int LEN_W       = 5;
  localparam int SHORT_MAX   = 4;
  localparam int FULL_MIN    = 5;
  localparam int VOWEL_SHORT = 3;
  localparam int FIFO_DEPTH  = 8;

  localparam logic [DEPTH_W-1:0] DEPTH_RESET = 3'h0;
  localparam logic [KW_IDX_W-1:0] KW_NONE    = 4'hf;

  typedef logic [KW_CHARS*8-1:0] kw_text_type;

  // Keyword table: full spellings, upper case, left aligned, space padded.
  localparam kw_text_type KW_TABLE [KW_COUNT] = '{
    "ABORT       ", "CALIBRATE   ", "DISPLAY     ", "INITIATE    ",
    "LIST        ", "MEASURE     ", "OUTPUT      ", "SOURCE      ",
    "STATUS      ", "SYSTEM      ", "TRIGGER     ", "VOLTAGE     ",
    "CURRENT     ", "LEVEL       ", "IMMEDIATE   ", "MODE        "
  };

  typedef enum logic [5:0] {
    ST_KEYWORD = 6'h01,
    ST_QUERY   = 6'h02,
    ST_PARAM   = 6'h04,
    ST_EMIT    = 6'h08,
    ST_SKIP    = 6'h10,
    ST_HOLD    = 6'h20
  } state_type;

endpackage : msg_parser_pkg

/* File: core/scpi_message_parser.sv */
// Contract
// - A keyword abbreviates to itself up to four letters, otherwise to four letters or three if the fourth is a vowel.
// - Only the complete full spelling or exactly the abbreviation is accepted; anything else is an error.
// - Keyword matching ignores letter case.
// - A colon between keywords steps one level down the command hierarchy.
// - A question mark right after the last keyword marks the unit as a query.
// - A message is units plus a terminator, and a character with line end asserted also terminates; in the code a colon, space or ? after a keyword does not.
// - One space separated parameter, numeric or string, may follow the keyword.
// - Newline 0a or a character with line end asserted terminates; it closes the message and returns to the root.
// In the code a colon, space or ? after a keyword does not terminate even with line end asserted.
// - Semicolons split a message into units.
// - A leading colon on a unit resolves its first keyword from the root.
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------------------
// Output FIFO
// -----------------------------------------------------------------------------
module unit_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_q[rd_q];

  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : unit_fifo

// -----------------------------------------------------------------------------
// Parser
// -----------------------------------------------------------------------------
module scpi_message_parser (
  // Clock and reset
  input  wire logic                                i_ref_clk,
  input  wire logic                                i_nrst,
  // Character stream from the host port
  input  wire logic                                i_chr_valid,
  input  wire logic [7:0]                          i_chr_data,
  input  wire logic                                i_line_end_assert,
  output logic                                     o_chr_ready,
  // Parsed message units
  output logic                                     o_unit_valid,
  input  wire logic                                i_unit_ready,
  output logic [msg_parser_pkg::DEPTH_W*msg_parser_pkg::KW_IDX_W-1:0] o_unit_path,
  output logic [msg_parser_pkg::DEPTH_W-1:0]       o_unit_depth,
  output logic                                     o_unit_query,
  output logic                                     o_unit_has_param,
  output logic [msg_parser_pkg::PARAM_CHARS*8-1:0] o_unit_param,
  output logic                                     o_unit_msg_end,
  // Status
  output logic                                     o_cmd_error
);
  localparam int KW  = msg_parser_pkg::KW_IDX_W;
  localparam int DW  = msg_parser_pkg::DEPTH_W;
  localparam int PW  = msg_parser_pkg::PARAM_CHARS*8;
  localparam int UW  = DW*KW + DW + 3 + PW;
  localparam int NK  = msg_parser_pkg::KW_CHARS;

  msg_parser_pkg::state_type state_q;
  logic [NK*8-1:0]    word_q;
  logic [msg_parser_pkg::LEN_W-1:0] wlen_q;
  logic [DW*KW-1:0]   path_q;
  logic [DW*KW-1:0]   path_vis;
  logic [DW-1:0]      depth_q;
  logic [DW-1:0]      base_q;
  logic               query_q;
  logic               hasp_q;
  logic               end_q;
  logic [PW-1:0]      param_q;
  logic [msg_parser_pkg::LEN_W-1:0] plen_q;
  logic               err_q;
  logic [UW-1:0]      unit_d;
  logic               fifo_ready;
  logic               unit_push;
  logic               take;
  logic               term;
  logic [7:0]         up_chr;
  logic [KW-1:0]      match_idx;
  logic               word_ok;
  logic               overflow;

  // Upper-case folding makes comparison blind to case.
  assign up_chr = ((i_chr_data >= 8'h61) && (i_chr_data <= 8'h7a)) ?
                  (i_chr_data & ~msg_parser_pkg::CASE_BIT) : i_chr_data;
  assign term   = (i_chr_data == msg_parser_pkg::CHR_NEWLINE) || i_line_end_assert;
  assign take   = i_chr_valid && o_chr_ready;
  assign o_chr_ready = (state_q != msg_parser_pkg::ST_EMIT) &&
                       (state_q != msg_parser_pkg::ST_HOLD);
  assign unit_push = (state_q == msg_parser_pkg::ST_EMIT);
  assign overflow  = (depth_q == '1);

  // Short form: whole word up to four letters, else four, or three on a vowel.
  function automatic logic [msg_parser_pkg::LEN_W-1:0] short_len(input logic [NK*8-1:0] w);
    logic [msg_parser_pkg::LEN_W-1:0] n;
    logic [7:0] c4;
    n  = '0;
    c4 = w[NK*8-25 -: 8];
    for (int i = 0; i < NK; i++)
    begin
      if (w[NK*8-1-8*i -: 8] != msg_parser_pkg::CHR_SPACE)
      begin
        n = msg_parser_pkg::LEN_W'(i + 1);
      end
    end
    if (n >= msg_parser_pkg::LEN_W'(msg_parser_pkg::FULL_MIN))
    begin
      n = msg_parser_pkg::LEN_W'(msg_parser_pkg::SHORT_MAX);
      if (c4 == "A" || c4 == "E" || c4 == "I" || c4 == "O" || c4 == "U")
      begin
        n = msg_parser_pkg::LEN_W'(msg_parser_pkg::VOWEL_SHORT);
      end
    end
    return n;
  endfunction : short_len

  // Exact full or exact short spelling only.
  always_comb
  begin
    logic [NK*8-1:0] full;
    logic [msg_parser_pkg::LEN_W-1:0] sl;
    logic            same_prefix;
    full        = '0;
    sl          = '0;
    same_prefix = 1'b0;
    match_idx = msg_parser_pkg::KW_NONE;
    word_ok   = 1'b0;
    for (int k = 0; k < msg_parser_pkg::KW_COUNT; k++)
    begin
      full = msg_parser_pkg::KW_TABLE[k];
      sl   = short_len(full);
      same_prefix = 1'b1;
      for (int i = 0; i < NK; i++)
      begin
        if ((msg_parser_pkg::LEN_W'(i) < sl) && (word_q[NK*8-1-8*i -: 8] != full[NK*8-1-8*i -: 8]))
        begin
          same_prefix = 1'b0;
        end
      end
      if ((word_q == full) || (same_prefix && (wlen_q == sl)))
      begin
        if (!word_ok)
        begin
          match_idx = KW'(k);
        end
        word_ok = 1'b1;
      end
    end
  end

  // Levels above the current depth keep keywords of earlier units, so they are masked off.
  always_comb
  begin
    path_vis = '0;
    for (int l = 0; l < DW; l++)
    begin
      if (DW'(l) < depth_q)
      begin
        path_vis[l*KW +: KW] = path_q[l*KW +: KW];
      end
    end
  end

  assign unit_d = {path_vis, depth_q, query_q, hasp_q, end_q, param_q};

  unit_fifo #(
    .WIDTH (UW),
    .DEPTH (msg_parser_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (unit_push),
    .i_in_data   (unit_d),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_unit_valid),
    .o_out_data  ({o_unit_path, o_unit_depth, o_unit_query, o_unit_has_param,
                   o_unit_msg_end, o_unit_param}),
    .i_out_ready (i_unit_ready)
  );

  assign o_cmd_error = err_q;

  // ---------------------------------------------------------------------------
  // Character sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q <= msg_parser_pkg::ST_KEYWORD;
      word_q  <= {NK{msg_parser_pkg::CHR_SPACE}};
      wlen_q  <= '0;
      path_q  <= '0;
      depth_q <= msg_parser_pkg::DEPTH_RESET;
      base_q  <= msg_parser_pkg::DEPTH_RESET;
      query_q <= 1'b0;
      hasp_q  <= 1'b0;
      end_q   <= 1'b0;
      param_q <= '0;
      plen_q  <= '0;
      err_q   <= 1'b0;
    end
    else
    begin
      err_q <= 1'b0;
      case (state_q)
        msg_parser_pkg::ST_KEYWORD:
        begin
          if (take)
          begin
            if (i_chr_data == msg_parser_pkg::CHR_COLON || term ||
                i_chr_data == msg_parser_pkg::CHR_SPACE ||
                i_chr_data == msg_parser_pkg::CHR_QUERY ||
                i_chr_data == msg_parser_pkg::CHR_SEMI)
            begin
              if (wlen_q == '0)
              begin
                if (i_chr_data == msg_parser_pkg::CHR_COLON && depth_q == base_q)
                begin
                  depth_q <= msg_parser_pkg::DEPTH_RESET;
                  base_q  <= msg_parser_pkg::DEPTH_RESET;
                end
                else if (term)
                begin
                  depth_q <= msg_parser_pkg::DEPTH_RESET;
                  base_q  <= msg_parser_pkg::DEPTH_RESET;
                end
                else
                begin
                  // A semicolon is itself the next separator, so parsing resumes at once.
                  err_q   <= 1'b1;
                  state_q <= (i_chr_data == msg_parser_pkg::CHR_SEMI) ?
                             msg_parser_pkg::ST_KEYWORD : msg_parser_pkg::ST_SKIP;
                end
              end
              else if (!word_ok || overflow)
              begin
                err_q   <= 1'b1;
                state_q <= (term || i_chr_data == msg_parser_pkg::CHR_SEMI) ?
                           msg_parser_pkg::ST_KEYWORD : msg_parser_pkg::ST_SKIP;
                if (term)
                begin
                  depth_q <= msg_parser_pkg::DEPTH_RESET;
                  base_q  <= msg_parser_pkg::DEPTH_RESET;
                end
                else
                begin
                  depth_q <= base_q;
                end
              end
              else
              begin
                path_q[depth_q*KW +: KW] <= match_idx;
                depth_q <= depth_q + 1'b1;
                if (i_chr_data == msg_parser_pkg::CHR_QUERY)
                begin
                  query_q <= 1'b1;
                  state_q <= msg_parser_pkg::ST_QUERY;
                end
                else if (i_chr_data == msg_parser_pkg::CHR_SPACE)
                begin
                  state_q <= msg_parser_pkg::ST_PARAM;
                end
                else if (i_chr_data != msg_parser_pkg::CHR_COLON)
                begin
                  end_q   <= term;
                  state_q <= msg_parser_pkg::ST_EMIT;
                end
              end
              word_q <= {NK{msg_parser_pkg::CHR_SPACE}};
              wlen_q <= '0;
            end
            else if (wlen_q == msg_parser_pkg::LEN_W'(NK))
            begin
              err_q   <= 1'b1;
              depth_q <= base_q;
              state_q <= msg_parser_pkg::ST_SKIP;
            end
            else
            begin
              word_q[NK*8-1-8*wlen_q -: 8] <= up_chr;
              wlen_q <= wlen_q + 1'b1;
            end
          end
        end
        msg_parser_pkg::ST_QUERY:
        begin
          if (take)
          begin
            if (i_chr_data == msg_parser_pkg::CHR_SPACE)
            begin
              state_q <= msg_parser_pkg::ST_PARAM;
            end
            else if (term || i_chr_data == msg_parser_pkg::CHR_SEMI)
            begin
              end_q   <= term;
              state_q <= msg_parser_pkg::ST_EMIT;
            end
            else
            begin
              err_q   <= 1'b1;
              query_q <= 1'b0;
              depth_q <= base_q;
              state_q <= msg_parser_pkg::ST_SKIP;
            end
          end
        end
        msg_parser_pkg::ST_PARAM:
        begin
          if (take)
          begin
            if (term || i_chr_data == msg_parser_pkg::CHR_SEMI)
            begin
              end_q   <= term;
              state_q <= msg_parser_pkg::ST_EMIT;
            end
            else if (plen_q == msg_parser_pkg::LEN_W'(msg_parser_pkg::PARAM_CHARS))
            begin
              err_q   <= 1'b1;
              query_q <= 1'b0;
              hasp_q  <= 1'b0;
              param_q <= '0;
              plen_q  <= '0;
              depth_q <= base_q;
              state_q <= msg_parser_pkg::ST_SKIP;
            end
            else
            begin
              hasp_q  <= 1'b1;
              param_q <= {param_q[PW-9:0], i_chr_data};
              plen_q  <= plen_q + 1'b1;
            end
          end
        end
        msg_parser_pkg::ST_EMIT:
        begin
          state_q <= msg_parser_pkg::ST_HOLD;
        end
        msg_parser_pkg::ST_HOLD:
        begin
          // Wait only when the FIFO filled, so the sender is back-pressured.
          if (fifo_ready)
          begin
            query_q <= 1'b0;
            hasp_q  <= 1'b0;
            param_q <= '0;
            plen_q  <= '0;
            end_q   <= 1'b0;
            state_q <= msg_parser_pkg::ST_KEYWORD;
            if (end_q)
            begin
              depth_q <= msg_parser_pkg::DEPTH_RESET;
              base_q  <= msg_parser_pkg::DEPTH_RESET;
            end
            else
            begin
              depth_q <= depth_q - 1'b1;
              base_q  <= depth_q - 1'b1;
            end
          end
        end
        msg_parser_pkg::ST_SKIP:
        begin
          if (take && (term || i_chr_data == msg_parser_pkg::CHR_SEMI))
          begin
            state_q <= msg_parser_pkg::ST_KEYWORD;
            if (term)
            begin
              depth_q <= msg_parser_pkg::DEPTH_RESET;
              base_q  <= msg_parser_pkg::DEPTH_RESET;
            end
          end
        end
        default:
        begin
          state_q <= msg_parser_pkg::ST_KEYWORD;
        end
      endcase
    end
  end

endmodule : scpi_message_parser
`default_nettype wire

/* File: verif/host_char_source.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Host controller sending program messages
// ------------------------------------------------------------
module host_char_source (
  // Clock and flow control
  input  wire logic       i_ref_clk,
  input  wire logic       i_chr_ready,
  // Character stream
  output logic            o_chr_valid,
  output logic [7:0]      o_chr_data,
  output logic            o_line_end_assert
);
  initial
  begin
    o_chr_valid       = 1'h0;
    o_chr_data        = 8'h00;
    o_line_end_assert = 1'h0;
  end

  // Idle data shows the inverse of the last character, so a stale value never matches.
  task automatic send(input string s, input bit line_end_assert, input int gap, output bit ok);
    int n;
    ok = 1'b1;
    for (int i = 0; i < s.len(); i++)
    begin
      @(negedge i_ref_clk);
      o_chr_valid       = 1'h1;
      o_chr_data        = s[i];
      o_line_end_assert = line_end_assert && (i == s.len() - 1);
      #1;
      n = 0;
      while (i_chr_ready !== 1'h1 && n < 200)
      begin
        @(negedge i_ref_clk);
        #1;
        n++;
      end
      if (i_chr_ready !== 1'h1)
      begin
        ok = 1'b0;
        return;
      end
      @(posedge i_ref_clk);
      if (gap > 0)
      begin
        @(negedge i_ref_clk);
        o_chr_valid = 1'h0;
        o_chr_data  = ~o_chr_data;
        repeat (gap - 1) @(negedge i_ref_clk);
      end
    end
    @(negedge i_ref_clk);
    o_chr_valid       = 1'h0;
    o_chr_data        = ~o_chr_data;
    o_line_end_assert = 1'h0;
  endtask : send
endmodule : host_char_source

`default_nettype wire

/* File: verif/msg_parser_checker.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Port checker for the message parser
// ------------------------------------------------------------
module msg_parser_checker (
  // Clock and reset
  input wire logic                                  i_ref_clk,
  input wire logic                                  i_nrst,
  // Character stream
  input wire logic                                  i_chr_valid,
  input wire logic [7:0]                            i_chr_data,
  input wire logic                                  i_line_end_assert,
  input wire logic                                  o_chr_ready,
  // Units and status
  input wire logic                                  o_unit_valid,
  input wire logic                                  i_unit_ready,
  input wire logic [msg_parser_pkg::DEPTH_W*msg_parser_pkg::KW_IDX_W-1:0] o_unit_path,
  input wire logic [msg_parser_pkg::DEPTH_W-1:0]    o_unit_depth,
  input wire logic                                  o_unit_query,
  input wire logic                                  o_unit_has_param,
  input wire logic [msg_parser_pkg::PARAM_CHARS*8-1:0] o_unit_param,
  input wire logic                                  o_unit_msg_end,
  input wire logic                                  o_cmd_error
);
  logic take;

  assign take = i_chr_valid && o_chr_ready;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  err_pulse_a: assert property (o_cmd_error |=> !o_cmd_error)
    else $error("command error flag held longer than one cycle");
  err_cause_a: assert property (o_cmd_error |-> $past(take))
    else $error("command error without a character taken the cycle before");
  emit_gap_a: assert property ($fell(o_chr_ready) |=> !o_chr_ready)
    else $error("character ready came back after one cycle");
  push_emit_a: assert property ($rose(o_unit_valid) |-> $past(!o_chr_ready))
    else $error("unit appeared without an emit cycle");
  push_delay_a: assert property ($rose(o_unit_valid) |-> $past(take, 2))
    else $error("unit appeared not two cycles after its closing character");
  unit_hold_a: assert property (o_unit_valid && !i_unit_ready |=> o_unit_valid
    && $stable(o_unit_path) && $stable(o_unit_query) && $stable(o_unit_param))
    else $error("unit changed while stalled");
  depth_set_a: assert property (o_unit_valid |-> o_unit_depth != 3'h0)
    else $error("unit with no keyword level");
  param_last_a: assert property (o_unit_valid && o_unit_has_param
    |-> o_unit_param[7:0] != 8'h00)
    else $error("parameter flagged but last character empty");

  cover property (o_unit_valid && o_unit_query);
  cover property (o_unit_valid && o_unit_has_param);
  cover property (o_cmd_error);
  cover property (!o_chr_ready && o_unit_valid && !i_unit_ready);
endmodule : msg_parser_checker

bind scpi_message_parser msg_parser_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_chr_valid(i_chr_valid),
  .i_chr_data(i_chr_data), .i_line_end_assert(i_line_end_assert),
  .o_chr_ready(o_chr_ready), .o_unit_valid(o_unit_valid), .i_unit_ready(i_unit_ready),
  .o_unit_path(o_unit_path), .o_unit_depth(o_unit_depth), .o_unit_query(o_unit_query),
  .o_unit_has_param(o_unit_has_param), .o_unit_param(o_unit_param),
  .o_unit_msg_end(o_unit_msg_end), .o_cmd_error(o_cmd_error)
);

`default_nettype wire

/* File: verif/scpi_message_parser_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module scpi_message_parser_tb;
  typedef struct {logic [11:0] p; logic [2:0] d; logic q; logic hp; logic me;
    logic [127:0] pr;} unit_type;
  typedef struct {string s; logic line_end_assert; logic [11:0] p; logic [2:0] d; logic q;
    logic hp; logic [15:0] pr; logic er;} row_type;

  logic         clk, nrst, chr_valid, line_end, chr_ready, unit_valid, unit_ready;
  logic         q, hp, me, err;
  logic [7:0]   chr_data;
  logic [11:0]  path;
  logic [2:0]   depth;
  logic [127:0] prm;
  int           fail_count, checked, errs;
  unit_type     got[$];
  row_type      rows[10] = '{
    '{"VOLT?\n", 1'h0, 12'h00b, 3'h1, 1'h1, 1'h0, 16'h0, 1'h0},
    '{"voltage\n", 1'h0, 12'h00b, 3'h1, 1'h0, 1'h0, 16'h0, 1'h0},
    '{"MEAS:CURR?\n", 1'h0, 12'h0c5, 3'h2, 1'h1, 1'h0, 16'h0, 1'h0},
    '{"CURR 5\n", 1'h0, 12'h00c, 3'h1, 1'h0, 1'h1, 16'h0035, 1'h0},
    '{"OutP ON\n", 1'h0, 12'h006, 3'h1, 1'h0, 1'h1, 16'h4f4e, 1'h0},
    '{"LEV\n", 1'h0, 12'h00d, 3'h1, 1'h0, 1'h0, 16'h0, 1'h0},
    '{"MODE\n", 1'h0, 12'h00f, 3'h1, 1'h0, 1'h0, 16'h0, 1'h0},
    '{"TRIG#", 1'h1, 12'h00a, 3'h1, 1'h0, 1'h0, 16'h0, 1'h0},
    '{"IMME\n", 1'h0, 12'h0, 3'h0, 1'h0, 1'h0, 16'h0, 1'h1},
    '{"MEA\n", 1'h0, 12'h0, 3'h0, 1'h0, 1'h0, 16'h0, 1'h1}};

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  scpi_message_parser u_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_chr_valid(chr_valid),
    .i_chr_data(chr_data), .i_line_end_assert(line_end), .o_chr_ready(chr_ready),
    .o_unit_valid(unit_valid), .i_unit_ready(unit_ready), .o_unit_path(path),
    .o_unit_depth(depth), .o_unit_query(q), .o_unit_has_param(hp), .o_unit_param(prm),
    .o_unit_msg_end(me), .o_cmd_error(err));
  host_char_source u_host (.i_ref_clk(clk), .i_chr_ready(chr_ready), .o_chr_valid(chr_valid),
    .o_chr_data(chr_data), .o_line_end_assert(line_end));

  always @(posedge clk)
  begin
    if (unit_valid === 1'h1 && unit_ready === 1'h1) got.push_back('{path, depth, q, hp, me, prm});
    if (err === 1'h1) errs++;
  end

  task check(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task complete_run;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  task send(input string s, input bit line_end_assert);
    bit ok;
    u_host.send(s, line_end_assert, 0, ok);
    if (!ok)
    begin
      fail_count++;
      complete_run();
    end
  endtask : send

  // A unit shows two cycles after its closing character and an error one cycle after.
  task drain;
    int n;
    repeat (3) @(negedge clk);
    for (n = 0; n < 40 && (unit_valid !== 1'h0 || chr_ready !== 1'h1); n++) @(negedge clk);
    if (n == 40)
    begin
      fail_count++;
      complete_run();
    end
  endtask : drain

  task unit_is(input int i, input logic [11:0] p, input logic [2:0] d, input logic m);
    check(got[i].p, p);
    check(got[i].d, d);
    check(got[i].me, m);
  endtask : unit_is

  initial
  begin
    nrst = 1'h0;
    unit_ready = 1'h1;
    repeat (6) @(negedge clk);
    check({chr_ready, unit_valid, err}, 3'h4);
    nrst = 1'h1;
    foreach (rows[k])
    begin
      errs = 0;
      got.delete();
      send(rows[k].s, rows[k].line_end_assert);
      drain();
      check(128'(errs), rows[k].er);
      check(128'(got.size()), !rows[k].er);
      if (got.size() > 0)
      begin
        unit_is(0, rows[k].p, rows[k].d, 1'h1);
        check(got[0].q, rows[k].q);
        check(got[0].hp, rows[k].hp);
        if (rows[k].hp) check(got[0].pr, {112'h0, rows[k].pr});
      end
      $display("row %0d done", k);
    end
    got.delete();
    send("MEAS:VOLT?;CURR?;:CURR?\n", 1'b0);
    drain();
    check(128'(got.size()), 128'h3);
    unit_is(0, 12'h0b5, 3'h2, 1'h0);
    unit_is(1, 12'h0c5, 3'h2, 1'h0);
    unit_is(2, 12'h00c, 3'h1, 1'h1);
    $display("split and root test done");
    got.delete();
    errs = 0;
    send("BOGUS;LIST\n", 1'b0);
    drain();
    check(128'(errs), 128'h1);
    unit_is(0, 12'h004, 3'h1, 1'h1);
    $display("resume test done");
    got.delete();
    unit_ready = 1'h0;
    fork
      send("LIST;LIST;LIST;LIST;LIST;LIST;LIST;LIST;LIST;LIST\n", 1'b0);
      begin
        repeat (90) @(negedge clk);
        check({chr_ready, unit_valid}, 2'h1);
        unit_ready = 1'h1;
      end
    join
    drain();
    check(128'(got.size()), 128'ha);
    foreach (got[i]) unit_is(i, 12'h004, 3'h1, i == 9);
    $display("buffer test done");
    complete_run();
  end
endmodule : scpi_message_parser_tb

`default_nettype wire
